// *** hoc_cfg.svh ***
// constants for the hall output conditioning block
`ifndef HOC_CFG_SVH
`define HOC_CFG_SVH

// ***************************************************************
// widths
// ***************************************************************
`define HOC_ADDR_W 8
`define HOC_HALL_W 16
`define HOC_RES_W 18
`define HOC_CODE_W 12
`define HOC_LINES 3

// ***************************************************************
// register offsets
// ***************************************************************
`define HOC_OFS_LPSEL 8'h00
`define HOC_OFS_CLAMP_LO 8'h04
`define HOC_OFS_CLAMP_HI 8'h08
`define HOC_OFS_CHECK 8'h0C
`define HOC_OFS_CTRL 8'h10
`define HOC_OFS_STATUS 8'h14

// ***************************************************************
// field positions
// ***************************************************************
`define HOC_CHK_LPAR_LSB 0
`define HOC_CHK_COLPAR_LSB 4
`define HOC_CTRL_CLAMP_EN 0
`define HOC_ST_CODE_LSB 0
`define HOC_ST_CORRECTED 16
`define HOC_ST_UNCORR 17
`define HOC_ST_UNDER 18
`define HOC_ST_OVER 19
`define HOC_LPSEL_BYPASS 3'h7

// ***************************************************************
// reset values
// ***************************************************************
`define HOC_RST_LPSEL 12'h000
`define HOC_RST_CLAMP_LO 12'h000
`define HOC_RST_CLAMP_HI 12'hFFF
`define HOC_RST_LPAR 3'h0
`define HOC_RST_COLPAR 12'hFFF
`define HOC_RST_CLAMP_EN 1'h1

// ***************************************************************
// output levels
// ***************************************************************
`define HOC_CODE_FULL 12'hFFF
`define HOC_CODE_SUPPLY 12'hF85

// ***************************************************************
// timing
// ***************************************************************
`define HOC_CLK_HZ 200000000
`define HOC_LPF_RATE_HZ 16000
`define HOC_INT_RATE_HZ 256000
`define HOC_LPF_DIV (`HOC_CLK_HZ / `HOC_LPF_RATE_HZ)
`define HOC_INT_DIV (`HOC_CLK_HZ / `HOC_INT_RATE_HZ)
`define HOC_LPF_FRAC 8
`define HOC_INT_FRAC 4
`define HOC_INT_SHIFT 2

`endif

// *** hoc_pkg.sv ***
// types shared by the hall output conditioning block
`include "hoc_cfg.svh"

package hoc_pkg;

    typedef struct packed {
        logic valid;
        logic signed [`HOC_HALL_W-1:0] data;
    } hoc_sample_t;

    typedef enum logic [2:0] {
        HOC_MODE_RUN = 3'b001,
        HOC_MODE_SUPPLY = 3'b010,
        HOC_MODE_MEMORY = 3'b100
    } hoc_mode_t;

    typedef struct packed {
        logic [2:0] lowpass_select;
        logic [`HOC_CODE_W-1:0] clamp_low_level;
        logic [`HOC_CODE_W-1:0] clamp_high_level;
    } hoc_settings_t;

endpackage

// *** hoc_buf2.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
`include "hoc_cfg.svh"

module hoc_buf2 (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // filling side
    input wire hoc_pkg::hoc_sample_t i_in,
    output logic o_in_ready,
    // draining side
    output hoc_pkg::hoc_sample_t o_out,
    input wire logic i_out_ready
);
    import hoc_pkg::*;

    logic [1:0] count;
    logic [1:0] next_count;
    logic signed [`HOC_HALL_W-1:0] head;
    logic signed [`HOC_HALL_W-1:0] next_head;
    logic signed [`HOC_HALL_W-1:0] tail;
    logic signed [`HOC_HALL_W-1:0] next_tail;
    logic push;
    logic pop;

    assign o_in_ready = (count != 2'h2);
    assign o_out.valid = (count != 2'h0);
    assign o_out.data = head;

    always_comb begin
        push = i_in.valid && o_in_ready;
        pop = o_out.valid && i_out_ready;
        next_count = count;
        next_head = head;
        next_tail = tail;
        if (push && !pop) begin
            next_count = 2'(count + 2'h1);
        end else if (pop && !push) begin
            next_count = 2'(count - 2'h1);
        end
        if (pop) begin
            next_head = tail;
        end
        if (push) begin
            if (count == 2'h0 || (count == 2'h1 && pop)) begin
                next_head = i_in.data;
            end else begin
                next_tail = i_in.data;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= 2'h0;
            head <= '0;
            tail <= '0;
        end else if (i_clk_en) begin
            count <= next_count;
            head <= next_head;
            tail <= next_tail;
        end
    end

endmodule
`default_nettype wire

// *** hoc_lpf.sv ***
// selectable first-order input low-pass filter
`timescale 1ns/10ps
`default_nettype none
`include "hoc_cfg.svh"

module hoc_lpf (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // control
    input wire logic [2:0] i_sel,
    input wire logic i_tick,
    // converter samples
    input wire hoc_pkg::hoc_sample_t i_in,
    output logic o_in_ready,
    // filtered samples
    output hoc_pkg::hoc_sample_t o_out,
    input wire logic i_out_ready
);
    import hoc_pkg::*;

    localparam int ACC_W = `HOC_HALL_W + `HOC_LPF_FRAC;

    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] next_acc;
    logic signed [`HOC_HALL_W-1:0] hold;
    logic signed [`HOC_HALL_W-1:0] next_hold;
    logic pend;
    logic next_pend;
    logic signed [ACC_W-1:0] x_ext;
    logic signed [ACC_W:0] diff;
    logic signed [ACC_W:0] step;
    logic signed [ACC_W:0] rounded;
    logic [2:0] shamt;

    assign o_in_ready = !pend;
    assign o_out.valid = pend;
    assign o_out.data = hold;

    always_comb begin
        x_ext = {i_in.data, {`HOC_LPF_FRAC{1'b0}}};
        shamt = 3'(3'h7 - i_sel);
        diff = {x_ext[ACC_W-1], x_ext} - {acc[ACC_W-1], acc};
        step = diff >>> shamt;
        rounded = {acc[ACC_W-1], acc} + (ACC_W+1)'(1 << (`HOC_LPF_FRAC - 1));
        next_acc = acc;
        next_hold = hold;
        next_pend = pend;
        if (i_in.valid && o_in_ready) begin
            if (i_sel == `HOC_LPSEL_BYPASS) begin
                next_acc = x_ext;
            end else begin
                next_acc = acc + step[ACC_W-1:0];
            end
        end
        if (pend && i_out_ready) begin
            next_pend = 1'b0;
        end else if (i_tick && !pend) begin
            next_pend = 1'b1;
            next_hold = rounded[ACC_W-1:`HOC_LPF_FRAC];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc <= '0;
            hold <= '0;
            pend <= 1'b0;
        end else if (i_clk_en) begin
            acc <= next_acc;
            hold <= next_hold;
            pend <= next_pend;
        end
    end

endmodule
`default_nettype wire

// *** hoc_top.sv ***
// hall sensor output conditioning: filters, clamping, error overrides
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "hoc_cfg.svh"

module hoc_top #(
    parameter int P_LPF_DIV = `HOC_LPF_DIV
) (
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // register port
    input wire logic [`HOC_ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // hall converter samples
    input wire hoc_pkg::hoc_sample_t i_hall,
    output logic o_hall_ready,
    // samples to processing core
    output hoc_pkg::hoc_sample_t o_core,
    input wire logic i_core_ready,
    // results from processing core
    input wire logic i_result_valid,
    input wire logic signed [`HOC_RES_W-1:0] i_result_data,
    // supply monitor pins
    input wire logic i_supply_under_threshold,
    input wire logic i_supply_over_threshold,
    // output converter
    output logic [`HOC_CODE_W-1:0] o_dac_code,
    output logic o_dac_strobe
);
    import hoc_pkg::*;

    localparam int INT_DIV = `HOC_INT_DIV;
    localparam int ZW = `HOC_CODE_W + `HOC_INT_FRAC;

    // ***************************************************************
    // rate ticks
    // ***************************************************************
    logic [13:0] lpf_cnt;
    logic [13:0] next_lpf_cnt;
    logic [9:0] int_cnt;
    logic [9:0] next_int_cnt;
    logic lpf_tick;
    logic int_tick;

    always_comb begin
        lpf_tick = (lpf_cnt == 14'(P_LPF_DIV - 1));
        int_tick = (int_cnt == 10'(INT_DIV - 1));
        next_lpf_cnt = lpf_tick ? 14'h0000 : 14'(lpf_cnt + 14'h0001);
        next_int_cnt = int_tick ? 10'h000 : 10'(int_cnt + 10'h001);
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lpf_cnt <= 14'h0000;
            int_cnt <= 10'h000;
        end else if (i_clk_en) begin
            lpf_cnt <= next_lpf_cnt;
            int_cnt <= next_int_cnt;
        end
    end

    // ***************************************************************
    // supply monitor synchronisers
    // ***************************************************************
    logic [1:0] sup_pin;
    logic [1:0] sup_s1;
    logic [1:0] sup_s2;
    logic [1:0] sup_s3;
    logic [1:0] sup_lvl;
    logic [1:0] next_sup_lvl;

    assign sup_pin = {i_supply_over_threshold, i_supply_under_threshold};
    genvar gs;
    generate
        for (gs = 0; gs < 2; gs++) begin : g_sync
            always_comb next_sup_lvl[gs] = (sup_s2[gs] == sup_s3[gs]) ? sup_s3[gs] : sup_lvl[gs];
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    sup_s1[gs] <= 1'b0;
                    sup_s2[gs] <= 1'b0;
                    sup_s3[gs] <= 1'b0;
                    sup_lvl[gs] <= 1'b0;
                end else if (i_clk_en) begin
                    sup_s1[gs] <= sup_pin[gs];
                    sup_s2[gs] <= sup_s1[gs];
                    sup_s3[gs] <= sup_s2[gs];
                    sup_lvl[gs] <= next_sup_lvl[gs];
                end
            end
        end
    endgenerate

    // ***************************************************************
    // settings registers
    // ***************************************************************
    logic [`HOC_CODE_W-1:0] line_q [`HOC_LINES];
    logic [`HOC_CODE_W-1:0] next_line [`HOC_LINES];
    logic [`HOC_LINES-1:0] lpar;
    logic [`HOC_LINES-1:0] next_lpar;
    logic [`HOC_CODE_W-1:0] colpar;
    logic [`HOC_CODE_W-1:0] next_colpar;
    logic clamp_en;
    logic next_clamp_en;

    always_comb begin
        next_lpar = lpar;
        next_colpar = colpar;
        next_clamp_en = clamp_en;
        if (i_reg_wr && i_reg_addr == `HOC_OFS_CHECK) begin
            next_lpar = i_reg_wdata[`HOC_CHK_LPAR_LSB +: `HOC_LINES];
            next_colpar = i_reg_wdata[`HOC_CHK_COLPAR_LSB +: `HOC_CODE_W];
        end else if (i_reg_wr && i_reg_addr == `HOC_OFS_CTRL) begin
            next_clamp_en = i_reg_wdata[`HOC_CTRL_CLAMP_EN];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lpar <= `HOC_RST_LPAR;
            colpar <= `HOC_RST_COLPAR;
            clamp_en <= `HOC_RST_CLAMP_EN;
        end else if (i_clk_en) begin
            lpar <= next_lpar;
            colpar <= next_colpar;
            clamp_en <= next_clamp_en;
        end
    end

    // ***************************************************************
    // per-line parity check and correction
    // ***************************************************************
    logic [`HOC_LINES-1:0] line_err;
    logic [`HOC_CODE_W-1:0] col_syn;
    logic [`HOC_CODE_W-1:0] line_fix [`HOC_LINES];
    logic [1:0] err_lines;
    logic mem_corrected;
    logic mem_uncorr;
    hoc_settings_t settings;

    genvar gl;
    generate
        for (gl = 0; gl < `HOC_LINES; gl++) begin : g_line
            localparam logic [`HOC_ADDR_W-1:0] LINE_OFS = (gl == 0) ? `HOC_OFS_LPSEL :
                (gl == 1) ? `HOC_OFS_CLAMP_LO : `HOC_OFS_CLAMP_HI;
            localparam logic [`HOC_CODE_W-1:0] LINE_RST = (gl == 0) ? `HOC_RST_LPSEL :
                (gl == 1) ? `HOC_RST_CLAMP_LO : `HOC_RST_CLAMP_HI;
            always_comb begin
                next_line[gl] = line_q[gl];
                if (i_reg_wr && i_reg_addr == LINE_OFS) begin
                    next_line[gl] = i_reg_wdata[`HOC_CODE_W-1:0];
                end
                line_err[gl] = (^line_q[gl]) ^ lpar[gl];
                line_fix[gl] = line_q[gl];
                if (line_err[gl] && err_lines == 2'h1) begin
                    line_fix[gl] = line_q[gl] ^ col_syn;
                end
            end
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    line_q[gl] <= LINE_RST;
                end else if (i_clk_en) begin
                    line_q[gl] <= next_line[gl];
                end
            end
        end
    endgenerate

    always_comb begin
        col_syn = colpar ^ line_q[0] ^ line_q[1] ^ line_q[2];
        err_lines = 2'({1'b0, line_err[0]} + {1'b0, line_err[1]} + {1'b0, line_err[2]});
        mem_corrected = (err_lines == 2'h1) && (col_syn != 12'h000);
        mem_uncorr = (err_lines >= 2'h2);
        settings.lowpass_select = line_fix[0][2:0];
        settings.clamp_low_level = line_fix[1];
        settings.clamp_high_level = line_fix[2];
    end

    // ***************************************************************
    // input filter path
    // ***************************************************************
    hoc_sample_t lpf_out;
    logic buf_ready;
    hoc_lpf u_lpf (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_sel(settings.lowpass_select),
        .i_tick(lpf_tick),
        .i_in(i_hall),
        .o_in_ready(o_hall_ready),
        .o_out(lpf_out),
        .i_out_ready(buf_ready)
    );

    hoc_buf2 u_buf (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_in(lpf_out),
        .o_in_ready(buf_ready),
        .o_out(o_core),
        .i_out_ready(i_core_ready)
    );

    // ***************************************************************
    // saturation, interpolation, clamping, overrides
    // ***************************************************************
    logic [`HOC_CODE_W-1:0] sat_code;
    logic [`HOC_CODE_W-1:0] next_sat_code;
    logic [ZW-1:0] interp;
    logic [ZW-1:0] next_interp;
    logic signed [ZW+1:0] idiff;
    logic signed [ZW+1:0] istep;
    logic [ZW:0] iround;
    logic [`HOC_CODE_W-1:0] int_code;
    logic [`HOC_CODE_W-1:0] clamp_a;
    logic [`HOC_CODE_W-1:0] clamp_b;
    hoc_mode_t mode;
    hoc_mode_t next_mode;
    logic [`HOC_CODE_W-1:0] next_dac_code;
    logic next_dac_strobe;

    always_comb begin
        next_sat_code = sat_code;
        if (i_result_valid) begin
            if (i_result_data < 0) begin
                next_sat_code = 12'h000;
            end else if (i_result_data > 18'sh00FFF) begin
                next_sat_code = `HOC_CODE_FULL;
            end else begin
                next_sat_code = i_result_data[`HOC_CODE_W-1:0];
            end
        end
        idiff = {2'b00, sat_code, {`HOC_INT_FRAC{1'b0}}} - {2'b00, interp};
        istep = idiff >>> `HOC_INT_SHIFT;
        next_interp = int_tick ? ZW'(interp + istep[ZW-1:0]) : interp;
        iround = {1'b0, interp} + (ZW+1)'(1 << (`HOC_INT_FRAC - 1));
        int_code = iround[ZW] ? `HOC_CODE_FULL : iround[ZW-1:`HOC_INT_FRAC];
        clamp_a = (clamp_en && int_code < settings.clamp_low_level)
            ? settings.clamp_low_level : int_code;
        clamp_b = (clamp_en && clamp_a > settings.clamp_high_level)
            ? settings.clamp_high_level : clamp_a;
        if (mem_uncorr) begin
            next_mode = HOC_MODE_MEMORY;
        end else if (sup_lvl != 2'b00) begin
            next_mode = HOC_MODE_SUPPLY;
        end else begin
            next_mode = HOC_MODE_RUN;
        end
        next_dac_code = o_dac_code;
        if (int_tick) begin
            case (mode)
                HOC_MODE_MEMORY: next_dac_code = `HOC_CODE_FULL;
                HOC_MODE_SUPPLY: next_dac_code = `HOC_CODE_SUPPLY;
                default: next_dac_code = clamp_b;
            endcase
        end
        next_dac_strobe = int_tick;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sat_code <= 12'h000;
            interp <= '0;
            mode <= HOC_MODE_RUN;
            o_dac_code <= 12'h000;
            o_dac_strobe <= 1'b0;
        end else if (i_clk_en) begin
            sat_code <= next_sat_code;
            interp <= next_interp;
            mode <= next_mode;
            o_dac_code <= next_dac_code;
            o_dac_strobe <= next_dac_strobe;
        end
    end

    // ***************************************************************
    // register read port
    // ***************************************************************
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h00000000;
        if (i_reg_rd) begin
            if (i_reg_addr == `HOC_OFS_LPSEL) begin
                next_rdata = {20'h00000, line_q[0]};
            end else if (i_reg_addr == `HOC_OFS_CLAMP_LO) begin
                next_rdata = {20'h00000, line_q[1]};
            end else if (i_reg_addr == `HOC_OFS_CLAMP_HI) begin
                next_rdata = {20'h00000, line_q[2]};
            end else if (i_reg_addr == `HOC_OFS_CHECK) begin
                next_rdata[`HOC_CHK_LPAR_LSB +: `HOC_LINES] = lpar;
                next_rdata[`HOC_CHK_COLPAR_LSB +: `HOC_CODE_W] = colpar;
            end else if (i_reg_addr == `HOC_OFS_CTRL) begin
                next_rdata[`HOC_CTRL_CLAMP_EN] = clamp_en;
            end else if (i_reg_addr == `HOC_OFS_STATUS) begin
                next_rdata[`HOC_ST_CODE_LSB +: `HOC_CODE_W] = o_dac_code;
                next_rdata[`HOC_ST_CORRECTED] = mem_corrected;
                next_rdata[`HOC_ST_UNCORR] = mem_uncorr;
                next_rdata[`HOC_ST_UNDER] = sup_lvl[0];
                next_rdata[`HOC_ST_OVER] = sup_lvl[1];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 32'h00000000;
        end else if (i_clk_en) begin
            o_reg_rdata <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// *** hoc_top_assertions.sv ***
// port checker for hoc_top
`timescale 1ns/10ps
`default_nettype none
`include "hoc_cfg.svh"
module hoc_top_chk (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // register port
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] o_reg_rdata,
    // stream and pins
    input wire hoc_pkg::hoc_sample_t o_core,
    input wire logic o_hall_ready,
    input wire logic i_core_ready,
    input wire logic i_supply_under_threshold,
    input wire logic i_supply_over_threshold,
    input wire logic [11:0] o_dac_code,
    input wire logic o_dac_strobe
);
    import hoc_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_fault; (i_supply_under_threshold || i_supply_over_threshold) [*8]; endsequence
    sequence s_stat; i_reg_rd && i_reg_addr == `HOC_OFS_STATUS; endsequence
    property p_pulse; o_dac_strobe |=> !o_dac_strobe; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_period; o_dac_strobe |-> ##[781:781] o_dac_strobe; endproperty
    a_period: assert property (p_period) else $error("tick period wrong");
    property p_hold; !o_dac_strobe |-> $stable(o_dac_code); endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    property p_fault; s_fault ##1 o_dac_strobe |-> o_dac_code inside
        {`HOC_CODE_SUPPLY, `HOC_CODE_FULL}; endproperty
    a_fault: assert property (p_fault) else $error("no fault code");
    property p_stat; s_stat |=> o_reg_rdata[11:0] == $past(o_dac_code); endproperty
    a_stat: assert property (p_stat) else $error("status code wrong");
    property p_unmap; i_reg_rd && i_reg_addr == 8'h20 |=> o_reg_rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_idle; !$past(i_reg_rd) |-> o_reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_core; o_core.valid && !i_core_ready |=> o_core.valid && $stable(o_core.data);
    endproperty
    a_core: assert property (p_core) else $error("word lost");
    property p_take; $rose(o_core.valid) |-> !$past(o_hall_ready); endproperty
    a_take: assert property (p_take) else $error("buffer filled without pending word");
endmodule
bind hoc_top hoc_top_chk chk_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
    .o_core(o_core), .o_hall_ready(o_hall_ready), .i_core_ready(i_core_ready),
    .i_supply_under_threshold(i_supply_under_threshold),
    .i_supply_over_threshold(i_supply_over_threshold),
    .o_dac_code(o_dac_code), .o_dac_strobe(o_dac_strobe));
`default_nettype wire

// *** hoc_dac_model.sv ***
// output converter as seen by the measuring device
`timescale 1ns/10ps
`default_nettype none
module hoc_dac_model (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // converter input
    input wire logic [11:0] i_code,
    input wire logic i_strobe,
    // level seen by the reader
    output logic [11:0] o_level,
    output logic o_new
);
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_level <= 12'h000;
            o_new <= 1'b0;
        end else begin
            o_new <= i_strobe;
            if (i_strobe) o_level <= i_code;
        end
    end
endmodule
`default_nettype wire

// *** hoc_top_tb.sv ***
// self-checking bench for hoc_top
`timescale 1ns/10ps
`default_nettype none
`include "hoc_cfg.svh"
module hoc_top_tb;
    import hoc_pkg::*;
    logic sys_clk = 0, resetn = 0, wr = 0, rd = 0, core_ready = 0, rd_seen = 0;
    logic res_valid = 0, uv = 0, ov = 0, hall_ready, strobe, new_code;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [17:0] res = 18'h0;
    logic [11:0] code, level;
    logic [15:0] x;
    hoc_sample_t hall = '0, core;
    int failures = 0, check_count = 0;
    logic [31:0] q_rd[$];
    logic [11:0] q_dac[$];
    logic [15:0] q_core[$];
    always #2.5 sys_clk = ~sys_clk;
    hoc_top #(.P_LPF_DIV(20)) dut_u (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_clk_en(1'b1),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_hall(hall), .o_hall_ready(hall_ready), .o_core(core),
        .i_core_ready(core_ready), .i_result_valid(res_valid), .i_result_data(res),
        .i_supply_under_threshold(uv), .i_supply_over_threshold(ov),
        .o_dac_code(code), .o_dac_strobe(strobe));
    hoc_dac_model dac_u (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_code(code),
        .i_strobe(strobe), .o_level(level), .o_new(new_code));
    // ****
    // tasks
    // ****
    task tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_dac(input logic [11:0] got, input logic [11:0] exp);
        cmp({20'h0, got}, {20'h0, exp});
    endtask
    task cmp_core(input logic [15:0] got, input logic [15:0] exp);
        cmp({16'h0, got}, {16'h0, exp});
    endtask
    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        q_rd.push_back(e);
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask
    task drain;
        int t;
        t = 0;
        while (q_rd.size() + q_dac.size() + q_core.size() > 0 && t < 2000) begin
            @(posedge sys_clk);
            t++;
        end
        if (t >= 2000) begin
            failures++;
            $display("BAD %0t no result", $time);
            tally_and_finish;
        end
    endtask
    task wait_strobes(input int n);
        int t;
        for (int k = 0; k < n; k++) begin
            t = 0;
            do begin
                @(posedge sys_clk);
                t++;
            end while (strobe !== 1'b1 && t < 1000);
            if (t >= 1000) begin
                failures++;
                $display("BAD %0t no strobe", $time);
                tally_and_finish;
            end
        end
        repeat (2) @(posedge sys_clk);
    endtask
    task exp_dac(input int n, input logic [11:0] e);
        wait_strobes(n);
        q_dac.push_back(e);
        drain;
    endtask
    task set_cfg(input logic [11:0] s, lo, hi, elo, ehi);
        logic [31:0] chk;
        chk = {16'h0, s ^ lo ^ hi, 1'b0, ^hi, ^lo, ^s};
        reg_wr(`HOC_OFS_LPSEL, {20'h0, s});
        reg_wr(`HOC_OFS_CLAMP_LO, {20'h0, lo ^ elo});
        reg_wr(`HOC_OFS_CLAMP_HI, {20'h0, hi ^ ehi});
        reg_wr(`HOC_OFS_CHECK, chk);
    endtask
    // ****
    // result monitor
    // ****
    always @(posedge sys_clk) begin
        core_ready <= 1'($urandom_range(1, 0));
        rd_seen <= rd;
        if (rd_seen) cmp(rdata, q_rd.pop_front());
        if (new_code === 1'b1 && q_dac.size() > 0) cmp_dac(level, q_dac.pop_front());
        if (core.valid === 1'b1 && core_ready && q_core.size() > 0) begin
            cmp_core(core.data, q_core.pop_front());
        end
    end
    // ****
    // scenarios
    // ****
    initial begin
        void'($urandom(43243));
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        reg_rd(`HOC_OFS_LPSEL, 32'h0);
        reg_rd(`HOC_OFS_CLAMP_HI, 32'hFFF);
        reg_rd(`HOC_OFS_CHECK, 32'hFFF0);
        reg_rd(`HOC_OFS_CTRL, 32'h1);
        reg_rd(8'h20, 32'h0);
        reg_rd(`HOC_OFS_STATUS, 32'h0);
        x = 16'($urandom_range(4095, 0));
        reg_wr(`HOC_OFS_CLAMP_LO, {16'h0, x});
        reg_rd(`HOC_OFS_CLAMP_LO, {16'h0, x});
        res_valid <= 1'b1;
        res <= 18'h1FFFF;
        set_cfg(12'h0, 12'h100, 12'hE00, 12'h0, 12'h0);
        exp_dac(16, 12'hE00);
        res <= 18'h3FFFB;
        exp_dac(16, 12'h100);
        set_cfg(12'h0, 12'hE00, 12'h100, 12'h0, 12'h0);
        exp_dac(2, 12'h100);
        set_cfg(12'h0, 12'hE00, 12'h100, 12'h0, 12'h080);
        exp_dac(2, 12'h100);
        reg_rd(`HOC_OFS_STATUS, 32'h00010100);
        set_cfg(12'h0, 12'hE00, 12'h100, 12'h001, 12'h080);
        exp_dac(2, 12'hFFF);
        uv <= 1'b1;
        exp_dac(2, 12'hFFF);
        set_cfg(12'h0, 12'hE00, 12'h100, 12'h0, 12'h0);
        exp_dac(2, 12'hF85);
        reg_wr(`HOC_OFS_STATUS, 32'h0);
        reg_rd(`HOC_OFS_STATUS, 32'h00040F85);
        uv <= 1'b0;
        ov <= 1'b1;
        exp_dac(2, 12'hF85);
        reg_rd(`HOC_OFS_STATUS, 32'h00080F85);
        ov <= 1'b0;
        reg_wr(`HOC_OFS_CTRL, 32'h0);
        exp_dac(2, 12'h000);
        for (int s = 0; s < 8; s++) begin
            x = 16'($urandom);
            set_cfg(s[11:0], 12'h0, 12'hFFF, 12'h0, 12'h0);
            hall <= {1'b1, x};
            wait_strobes(4);
            q_core.push_back(x);
            drain;
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
